//--- verilog/pos_pkg.sv
// Purpose: constants for the positioning option and slip monitor block
// Assumes: object-style register access by 16-bit index
// Notes:   one package shared by both design files
package pos_pkg;
  localparam logic [15:0] IDX_OPTION   = 16'h60F2;
  localparam logic [15:0] IDX_FOLLOW   = 16'h60F4;
  localparam logic [15:0] IDX_SLIP     = 16'h60F8;
  localparam logic [15:0] RST_OPTION   = 16'h0001;
  localparam logic [31:0] RST_SLIP     = 32'h0000_0190;
  localparam logic [31:0] SLIP_OFF     = 32'h07FF_FFFF;
  // option, control and status word field positions
  localparam int          REL_LSB      = 0;
  localparam int          REL_AUTO_LSB = 4;
  localparam int          ROT_LSB      = 6;
  localparam int          CW_RELATIVE  = 6;
  localparam int          CW_NEW_SP    = 4;
  localparam int          SW_SP_ACK    = 12;
  localparam int          SW_SLIP      = 13;
  // slippage time unit: one millisecond at 10 MHz
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          SLIP_UNIT_US = 1000;
  localparam int          SLIP_UNIT_CY = CLK_HZ / 1_000_000 * SLIP_UNIT_US;
  typedef enum logic [1:0] {REL_PREV, REL_RAMP, REL_ACTUAL, REL_RSVD} pos_rel_t;
  typedef enum logic [1:0] {AR_OFF, AR_ON_ARRIVE, AR_ASAP, AR_RSVD} pos_ar_t;
  typedef enum logic [1:0] {ROT_LINEAR, ROT_NEG, ROT_POS, ROT_SHORT} pos_rot_t;
endpackage

//--- verilog/pos_slip_mon.sv
// Purpose: speed deviation persistence timer for slippage detection
// Assumes: speeds synchronous to clk_i
// Notes:   time limit in millisecond units
`timescale 1ns/1ps
`default_nettype none
module pos_slip_mon
  import pos_pkg::*;
#(
  parameter int UNIT_CY = SLIP_UNIT_CY
)(
  input  wire logic        clk_i,
  input  wire logic        rst_ni,
  input  wire logic [31:0] act_speed_i,
  input  wire logic [31:0] set_speed_i,
  input  wire logic [31:0] max_slip_i,
  input  wire logic [15:0] slip_time_i,
  output logic             slip_o,
  output logic             slip_rise_o
);
  // refuse a unit step the prescaler cannot count
  if (UNIT_CY < 1) $error("UNIT_CY must be at least 1");
  logic signed [32:0] diff;
  logic        [32:0] mag;
  logic               over;
  logic        [31:0] pre_q;
  logic        [15:0] ms_q;
  logic               slip_q;
  // absolute deviation against limit
  always_comb
  begin
    diff = $signed({act_speed_i[31], act_speed_i}) - $signed({set_speed_i[31], set_speed_i});
    mag  = diff[32] ? 33'(-diff) : 33'(diff);
    over = (max_slip_i != SLIP_OFF) && (mag > {1'b0, max_slip_i});
  end
  // persistence counter in unit steps
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      pre_q  <= 32'h0000_0000;
      ms_q   <= 16'h0000;
      slip_q <= 1'b0;
    end
    else if (!over)
    begin
      pre_q  <= 32'h0000_0000;
      ms_q   <= 16'h0000;
      slip_q <= 1'b0;
    end
    else if (ms_q > slip_time_i)
      slip_q <= 1'b1;
    else if (pre_q == 32'(UNIT_CY - 1))
    begin
      pre_q <= 32'h0000_0000;
      ms_q  <= ms_q + 16'h0001;
    end
    else
      pre_q <= pre_q + 32'h0000_0001;
  end
  logic slip_d1_q;
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
      slip_d1_q <= 1'b0;
    else
      slip_d1_q <= slip_q;
  end
  assign slip_o      = slip_q;
  assign slip_rise_o = slip_q & ~slip_d1_q;
endmodule
`default_nettype wire

//--- verilog/pos_option_top.sv
// Purpose: positioning option word, following error and slippage status
// Assumes: master writes objects by index with a one-cycle strobe
// Notes:   position loop itself lives outside; this block steers it
// Operation
// - relative reference only for relative profile moves
// - mode 00 uses previous target or zero
// - mode 01 uses ramp generator output
// - mode 10 uses measured actual position
// - auto release clears new-setpoint bit itself
// - then clears setpoint-acknowledge status bit too
// - mode 00 leaves new-setpoint bit alone
// - mode 01 clears bit on target reached
// - mode 10 clears bit as soon as accepted
// - linear axis wraps setpoint at range limits
// - over-modulo moves only in linear mode
// - mode 01 moves only negatively
// - mode 10 moves only positively
// - mode 11 takes shortest path
// - following error reported signed, read only
// - status bit 13 on excess speed deviation
// - only after deviation outlasts slippage time
// - limit 07FFFFFFh disables slip monitor
// - configured reaction logs an error entry
`timescale 1ns/1ps
`default_nettype none
module pos_option_top
  import pos_pkg::*;
#(
  parameter int SLIP_UNIT = SLIP_UNIT_CY
)(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // object access
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] idx_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o,
  output logic             rvalid_o,
  output logic             rerr_o,
  // control word from master, status word bits
  input  wire logic [15:0] ctrl_word_i,
  input  wire logic        ctrl_wr_i,
  output logic      [15:0] ctrl_word_o,
  output logic             sp_ack_o,
  output logic             slip_status_o,
  // motion inputs
  input  wire logic        sp_accept_i,
  input  wire logic        target_reached_i,
  input  wire logic [31:0] target_i,
  input  wire logic [31:0] ramp_pos_i,
  input  wire logic [31:0] actual_pos_i,
  input  wire logic [31:0] demand_pos_i,
  input  wire logic [31:0] range_min_i,
  input  wire logic [31:0] range_max_i,
  input  wire logic [31:0] act_speed_i,
  input  wire logic [31:0] set_speed_i,
  input  wire logic [15:0] slip_time_i,
  input  wire logic        slip_react_en_i,
  // steering outputs
  output logic      [31:0] abs_target_o,
  output logic             dir_neg_o,
  output logic             allow_multi_turn_o,
  output logic             error_log_o
);
  // refuse a unit step the slip timer cannot count
  if (SLIP_UNIT < 1) $error("SLIP_UNIT must be at least 1");
  // reset release through two flops
  logic rst_s1_q;
  logic rst_ni;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1_q <= 1'b0;
      rst_ni   <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_ni   <= rst_s1_q;
    end
  end
  logic [15:0] option_q;
  logic [31:0] slip_q;
  logic [31:0] follow_q;
  logic [31:0] prev_tgt_q;
  logic        prev_vld_q;
  logic [15:0] ctrl_q;
  logic        ack_q;
  pos_rel_t    rel_sel;
  pos_ar_t     ar_sel;
  pos_rot_t    rot_sel;
  assign rel_sel = pos_rel_t'(option_q[REL_LSB +: 2]);
  assign ar_sel  = pos_ar_t'(option_q[REL_AUTO_LSB +: 2]);
  assign rot_sel = pos_rot_t'(option_q[ROT_LSB +: 2]);
  // writable objects
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      option_q <= RST_OPTION;
      slip_q   <= RST_SLIP;
    end
    else if (wr_i)
    begin
      if (idx_i == IDX_OPTION)
        option_q <= wdata_i[15:0];
      if (idx_i == IDX_SLIP)
        slip_q <= wdata_i;
    end
  end
  // following error sampled every cycle
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
      follow_q <= 32'h0000_0000;
    else
      follow_q <= demand_pos_i - actual_pos_i;
  end
  // read path, one cycle latency
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      rdata_o  <= 32'h0000_0000;
      rvalid_o <= 1'b0;
      rerr_o   <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_i;
      rerr_o   <= 1'b0;
      rdata_o  <= 32'h0000_0000;
      if (rd_i)
      begin
        unique case (idx_i)
          IDX_OPTION: rdata_o <= {16'h0000, option_q};
          IDX_FOLLOW: rdata_o <= follow_q;
          IDX_SLIP:   rdata_o <= slip_q;
          default:    rerr_o  <= 1'b1;
        endcase
      end
    end
  end
  // auto release of new-setpoint and its acknowledge
  logic release_now;
  always_comb
  begin
    unique case (ar_sel)
      AR_ON_ARRIVE: release_now = ctrl_q[CW_NEW_SP] & ack_q & target_reached_i;
      AR_ASAP:      release_now = ctrl_q[CW_NEW_SP] & sp_accept_i;
      default:      release_now = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
      ctrl_q <= 16'h0000;
    else if (ctrl_wr_i)
      ctrl_q <= ctrl_word_i;
    else if (release_now)
      ctrl_q[CW_NEW_SP] <= 1'b0;
  end
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
      ack_q <= 1'b0;
    else if (ctrl_q[CW_NEW_SP] & sp_accept_i)
      ack_q <= 1'b1;
    else if (release_now | ~ctrl_q[CW_NEW_SP])
      ack_q <= 1'b0;
  end
  assign ctrl_word_o = ctrl_q;
  assign sp_ack_o    = ack_q;
  // target resolution at setpoint acceptance
  logic [31:0] base;
  logic [31:0] raw_tgt;
  always_comb
  begin
    unique case (rel_sel)
      REL_RAMP:   base = ramp_pos_i;
      REL_ACTUAL: base = actual_pos_i;
      default:    base = prev_vld_q ? prev_tgt_q : 32'h0000_0000;
    endcase
    raw_tgt = ctrl_q[CW_RELATIVE] ? base + target_i : target_i;
  end
  // wrap into the range limits
  logic [31:0] span;
  logic [31:0] wrapped;
  always_comb
  begin
    span    = range_max_i - range_min_i;
    wrapped = raw_tgt;
    if ($signed(raw_tgt) > $signed(range_max_i))
      wrapped = raw_tgt - span;
    else if ($signed(raw_tgt) < $signed(range_min_i))
      wrapped = raw_tgt + span;
  end
  // direction choice on linear and rotary axis
  logic        dir_neg;
  logic [31:0] fwd;
  always_comb
  begin
    fwd = wrapped - actual_pos_i;
    if (span != 32'h0000_0000 && fwd >= span)
      fwd = fwd + span;
    unique case (rot_sel)
      ROT_NEG:    dir_neg = 1'b1;
      ROT_POS:    dir_neg = 1'b0;
      ROT_SHORT:  dir_neg = !(fwd < (span >> 1));
      ROT_LINEAR: dir_neg = $signed(wrapped) < $signed(actual_pos_i);
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      prev_tgt_q   <= 32'h0000_0000;
      prev_vld_q   <= 1'b0;
      abs_target_o <= 32'h0000_0000;
      dir_neg_o    <= 1'b0;
    end
    else if (ctrl_q[CW_NEW_SP] & sp_accept_i & ~ack_q)
    begin
      prev_tgt_q   <= wrapped;
      prev_vld_q   <= 1'b1;
      abs_target_o <= wrapped;
      dir_neg_o    <= dir_neg;
    end
  end
  assign allow_multi_turn_o = (rot_sel == ROT_LINEAR);
  // slippage monitor
  logic slip_rise;
  pos_slip_mon #(
    .UNIT_CY (SLIP_UNIT)
  ) u_slip (
    .clk_i       (clk_i),
    .rst_ni      (rst_ni),
    .act_speed_i (act_speed_i),
    .set_speed_i (set_speed_i),
    .max_slip_i  (slip_q),
    .slip_time_i (slip_time_i),
    .slip_o      (slip_status_o),
    .slip_rise_o (slip_rise)
  );
  // error history pulse when a reaction is set
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
      error_log_o <= 1'b0;
    else
      error_log_o <= slip_rise & slip_react_en_i;
  end
endmodule
`default_nettype wire

//--- dv/pos_option_props.sv
// Purpose: port checks for pos_option_top
// Assumes: no request before reset release
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module pos_option_props
  import pos_pkg::*;
#(
  parameter int SLIP_UNIT = SLIP_UNIT_CY
)(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        rd_i,
  input wire logic [15:0] idx_i,
  input wire logic        rvalid_o,
  input wire logic        rerr_o,
  input wire logic        ctrl_wr_i,
  input wire logic [15:0] ctrl_word_i,
  input wire logic [15:0] ctrl_word_o,
  input wire logic        sp_accept_i,
  input wire logic        sp_ack_o,
  input wire logic [31:0] act_speed_i,
  input wire logic [31:0] set_speed_i,
  input wire logic        slip_status_o,
  input wire logic        error_log_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // answers, handshakes and pulses
  read_answer_a: assert property (
    rd_i && idx_i == IDX_FOLLOW |=> rvalid_o && !rerr_o) else $error("no answer");
  bad_index_a: assert property (
    rd_i && idx_i[15:4] != 12'h60F |=> rerr_o) else $error("no refusal");
  read_cause_a: assert property (
    rvalid_o |-> $past(rd_i)) else $error("stray answer");
  ack_cause_a: assert property (
    $rose(sp_ack_o) |-> $past(ctrl_word_o[CW_NEW_SP] && sp_accept_i)) else $error("stray ack");
  ack_release_a: assert property (
    sp_ack_o && !ctrl_word_o[CW_NEW_SP] |=> !sp_ack_o) else $error("ack held");
  setpoint_rise_a: assert property (
    $rose(ctrl_word_o[CW_NEW_SP]) |-> $past(ctrl_wr_i && ctrl_word_i[CW_NEW_SP]))
    else $error("bit set by device");
  error_log_a: assert property (
    error_log_o |-> $past(slip_status_o) ##1 !error_log_o) else $error("bad log");
  slip_clear_a: assert property (
    (act_speed_i == set_speed_i) [*2] |=> !slip_status_o) else $error("slip held");
endmodule
bind pos_option_top pos_option_props #(.SLIP_UNIT(SLIP_UNIT)) u_props (.*);
`default_nettype wire

//--- dv/pos_master_model.sv
// Purpose: fieldbus master model
// Assumes: tasks start on a falling edge
// Notes: released lines show the inverse
`timescale 1ns/1ps
`default_nettype none
module pos_master_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        rerr_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [15:0] idx_o,
  output logic      [31:0] wdata_o,
  output logic      [15:0] cw_o,
  output logic             cw_wr_o
);
  // idle bus at time zero
  initial {wr_o, rd_o, idx_o, wdata_o, cw_o, cw_wr_o} = '0;
  // object write; reserved codes never sent
  task automatic obj_wr(input logic [15:0] i, input logic [31:0] d);
    @(negedge clk_i);
    {wr_o, idx_o, wdata_o} = {1'b1, i, d};
    @(negedge clk_i);
    {wr_o, idx_o, wdata_o} = {1'b0, ~i, ~d};
  endtask
  // object read, answer a cycle later
  task automatic obj_rd(input logic [15:0] i, output logic [31:0] d, output logic e);
    @(negedge clk_i);
    {rd_o, idx_o} = {1'b1, i};
    @(negedge clk_i);
    {rd_o, idx_o} = {1'b0, ~i};
    d = rdata_i;
    e = rerr_i;
  endtask
  // control word; master sets and resets the new setpoint bit
  task automatic cw_wr(input logic [15:0] w);
    @(negedge clk_i);
    {cw_wr_o, cw_o} = {1'b1, w};
    @(negedge clk_i);
    {cw_wr_o, cw_o} = {1'b0, ~w};
  endtask
endmodule
`default_nettype wire

//--- dv/test_positioning_option_slip_monitor.sv
// Purpose: bench for pos_option_top
// Assumes: slip unit of 2 cycles
// Notes: inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module test_positioning_option_slip_monitor
  import pos_pkg::*;
;
  logic clk_i = 0, rstn_i = 0, wr_i, rd_i, ctrl_wr_i, rvalid_o, rerr_o, sp_ack_o;
  logic dir_neg_o, slip_status_o, allow_multi_turn_o, error_log_o, target_reached_i = 0;
  logic sp_accept_i = 1, slip_react_en_i = 1;
  logic [15:0] idx_i, ctrl_word_i, ctrl_word_o, slip_time_i = 2;
  logic [31:0] rdata_o, wdata_i, abs_target_o, target_i = 0, ramp_pos_i = 0;
  logic [31:0] actual_pos_i = 0, demand_pos_i = 0, range_min_i = 0, range_max_i = 0;
  logic [31:0] act_speed_i = 0, set_speed_i = 0;
  int bad_count = 0, checks_done = 0, cyc = 0, logs = 0;
  // option, control word, target, expected target, expected direction (2: none)
  logic [31:0] tr [10][5] = '{'{0, 'h50, 10, 10, 2}, '{0, 'h50, 10, 20, 2},
    '{1, 'h50, 10, 1010, 2}, '{2, 'h50, 10, 2010, 2},
    '{2, 'h10, 10, 10, 2}, '{0, 'h10, 100010, 10, 2},
    '{'h40, 'h10, 300, 0, 1}, '{'h80, 'h10, 100, 0, 0},
    '{'hC0, 'h10, 250, 0, 0}, '{'hC0, 'h10, 100, 0, 1}};
  pos_option_top #(.SLIP_UNIT(2)) uut (.*);
  pos_master_model m (.clk_i(clk_i), .rdata_i(rdata_o), .rerr_i(rerr_o), .wr_o(wr_i),
    .rd_o(rd_i), .idx_o(idx_i), .wdata_o(wdata_i), .cw_o(ctrl_word_i), .cw_wr_o(ctrl_wr_i));
  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  // hang guard and log pulse count, sampled where outputs are settled
  always @(negedge clk_i)
  begin
    cyc++;
    logs += int'(error_log_o === 1'b1);
    if (cyc == 20000)
    begin
      bad_count++;
      summarize;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // setpoint request, bounded wait for ack
  task automatic move(input logic [31:0] cw, input logic [31:0] t);
    target_i = t;
    m.cw_wr(cw[15:0]);
    for (int n = 0; n < 9 && sp_ack_o !== 1'b1; n++)
      @(negedge clk_i);
  endtask
  task automatic row(input int i);
    m.obj_wr(IDX_OPTION, tr[i][0]);
    chk("multi", 32'(tr[i][0][7:6] == 2'b00), 32'(allow_multi_turn_o));
    move(tr[i][1], tr[i][2]);
    if (tr[i][4] < 2)
      chk("dir", tr[i][4], 32'(dir_neg_o));
    else
      chk("target", tr[i][3], abs_target_o);
    chk("held", 1, 32'(ctrl_word_o[4]));
    m.cw_wr(16'h0000);
    @(negedge clk_i);
    chk("ack", 0, 32'(sp_ack_o));
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    m.obj_rd(IDX_OPTION, d, e);
    chk("option", 32'(RST_OPTION), d);
    m.obj_rd(IDX_SLIP, d, e);
    chk("limit", RST_SLIP, d);
    m.obj_rd(16'h6000, d, e);
    chk("rerr", 1, 32'(e));
    {demand_pos_i, actual_pos_i} = {32'd100, 32'd150};
    m.obj_wr(IDX_FOLLOW, 32'h0000_0005);
    m.obj_rd(IDX_FOLLOW, d, e);
    chk("follow", 32'hFFFF_FFCE, d);
    $display("regs done");
  endtask
  task automatic t_rel;
    {range_max_i, ramp_pos_i, actual_pos_i} = {32'd100000, 32'd1000, 32'd2000};
    for (int i = 0; i < 6; i++)
      row(i);
    $display("relative done");
  endtask
  task automatic t_rot;
    {range_max_i, ramp_pos_i, actual_pos_i, demand_pos_i} = {32'd360, {3{32'd200}}};
    for (int i = 6; i < 10; i++)
      row(i);
    $display("rotary done");
  endtask
  task automatic t_release;
    m.obj_wr(IDX_OPTION, 32'h0000_0010);
    move(16'h0010, 32'd5);
    chk("arrive", 1, 32'(ctrl_word_o[4]));
    target_reached_i = 1'b1;
    @(negedge clk_i);
    target_reached_i = 1'b0;
    @(negedge clk_i);
    chk("freed", 0, 32'(ctrl_word_o[4]));
    @(negedge clk_i);
    chk("ack", 0, 32'(sp_ack_o));
    m.obj_wr(IDX_OPTION, 32'h0000_0020);
    sp_accept_i = 1'b0;
    move(16'h0010, 32'd6);
    chk("wait", 1, 32'(ctrl_word_o[4]));
    sp_accept_i = 1'b1;
    @(negedge clk_i);
    chk("asap", 0, 32'(ctrl_word_o[4]));
    chk("latched", 6, abs_target_o);
    $display("release done");
  endtask
  task automatic t_slip;
    m.obj_wr(IDX_SLIP, 32'h0000_000A);
    act_speed_i = 32'd50;
    repeat (4) @(negedge clk_i);
    chk("early", 0, 32'(slip_status_o));
    for (int n = 0; n < 20 && slip_status_o !== 1'b1; n++)
      @(negedge clk_i);
    chk("slip", 1, 32'(slip_status_o));
    repeat (3) @(negedge clk_i);
    chk("log", 1, logs);
    act_speed_i = 32'd0;
    repeat (2) @(negedge clk_i);
    chk("clear", 0, 32'(slip_status_o));
    slip_react_en_i = 1'b0;
    act_speed_i = 32'd50;
    for (int n = 0; n < 20 && slip_status_o !== 1'b1; n++)
      @(negedge clk_i);
    chk("again", 1, 32'(slip_status_o));
    repeat (3) @(negedge clk_i);
    chk("no log", 1, logs);
    m.obj_wr(IDX_SLIP, SLIP_OFF);
    act_speed_i = 32'd50;
    repeat (30) @(negedge clk_i);
    chk("off", 0, 32'(slip_status_o));
    $display("slip done");
  endtask
  // mid-run reset restores the objects and clears latched outputs
  task automatic t_reset;
    logic [31:0] d;
    logic e;
    m.obj_wr(IDX_OPTION, 32'h0000_0020);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("rst ack", 0, 32'(sp_ack_o));
    chk("rst target", 0, abs_target_o);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    m.obj_rd(IDX_OPTION, d, e);
    chk("rst option", 32'(RST_OPTION), d);
    m.obj_rd(IDX_SLIP, d, e);
    chk("rst limit", RST_SLIP, d);
    $display("reset done");
  endtask
  // reset, then the scenarios
  initial
  begin
    repeat (16) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_regs;
    t_rel;
    t_release;
    t_rot;
    t_slip;
    t_reset;
    summarize;
  end
endmodule
`default_nettype wire
